// ---- ckd_cfg.svh ----
`ifndef CKD_CFG_SVH
`define CKD_CFG_SVH
`define CKD_ADDR_CLKDIV    12'h000
`define CKD_ADDR_PWRCTL    12'h004
`define CKD_ADDR_CMPCTL    12'h008
`define CKD_ADDR_STATUS    12'h00C
`define CKD_BIT_UNLOCK     7
`define CKD_BIT_ARM        5
`define CKD_MODE_HI        4
`define CKD_MODE_LO        3
`define CKD_BIT_CMPDIS     7
`define CKD_SEL_W          4
`define CKD_SEL_MAX        4'h8
`define CKD_SEL_FUSE       4'h3
`define CKD_SEL_RST        4'h0
`define CKD_UNLOCK_CYC     3'h4
`define CKD_HOLD_CYC       3'h4
`define CKD_STARTUP_CYC    4'h6
`endif

// ---- ckd_pkg.sv ----
package ckd_pkg;
   typedef enum logic [1:0] {
      CKD_IDLE, CKD_NOISE, CKD_PDOWN, CKD_RSVD
   } ckd_mode_e;
   typedef enum logic [1:0] {
      CKD_RUN, CKD_SLEEP, CKD_START, CKD_HOLD
   } ckd_state_e;
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
   } ckd_clken_s;
   typedef struct packed {
      logic external_interrupt_zero_level;
      logic pin_change;
      logic watchdog;
      logic adc_done;
      logic mem_ready;
      logic comparator;
      logic other_io;
   } ckd_wake_s;
endpackage

// ---- ckd_clock_sleep.sv ----
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ckd_cfg.svh"
module ckd_clock_sleep
   import ckd_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        DIVIDE_BY_EIGHT_FUSE,
   input  wire logic        SLEEP_INSTR,
   input  wire logic        ADC_ENABLED,
   input  wire ckd_wake_s   WAKE_IRQ,
   output ckd_clken_s       CLK_EN,
   output logic             OSC_ENABLE,
   output logic             ADC_AUTO_START,
   output logic             INTR_WAKE,
   output logic             SLEEPING
);
   logic [`CKD_SEL_W-1:0] sel_r;
   logic                  unlock_r;
   logic [2:0]            unl_cnt_r;
   logic                  arm_r;
   logic [1:0]            mode_r;
   logic                  cmp_dis_r;
   logic [8:0]            div_cnt_r;
   logic [`CKD_SEL_W-1:0] act_sel_r;
   logic                  tick;
   ckd_state_e            state_r;
   ckd_mode_e             slp_mode_r;
   logic [3:0]            wait_r;
   logic                  fuse_taken_r;
   logic                  wr;
   logic                  rd;
   logic                  wake;
   logic [7:0]            clkdiv_rd;

   // Division factor minus one for a select code
   function automatic logic [8:0] div_last(input logic [3:0] s);
      logic [8:0] one;
      one = 9'h001;
      if (s > `CKD_SEL_MAX) begin
         div_last = 9'h000;
      end else begin
         div_last = (one << s) - 9'h001;
      end
   endfunction

   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && !PWRITE;
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;

   // Fuse is a level, so it is caught after reset release
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         fuse_taken_r <= 1'b0;
      end else begin
         fuse_taken_r <= 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sel_r <= `CKD_SEL_RST;
      end else if (!fuse_taken_r) begin
         sel_r <= DIVIDE_BY_EIGHT_FUSE ? `CKD_SEL_FUSE
                                       : `CKD_SEL_RST;
      end else if (wr && PADDR == `CKD_ADDR_CLKDIV && unlock_r
                   && !PWDATA[`CKD_BIT_UNLOCK]) begin
         sel_r <= PWDATA[`CKD_SEL_W-1:0];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         unlock_r  <= 1'b0;
         unl_cnt_r <= 3'h0;
      end else if (unlock_r) begin
         // Rewrite ignored; select write or timeout closes window
         if ((wr && PADDR == `CKD_ADDR_CLKDIV && !PWDATA[`CKD_BIT_UNLOCK])
             || unl_cnt_r == `CKD_UNLOCK_CYC - 3'h1) begin
            unlock_r <= 1'b0;
         end
         unl_cnt_r <= unl_cnt_r + 3'h1;
      end else if (wr && PADDR == `CKD_ADDR_CLKDIV
                   && PWDATA[7:0] == 8'h80) begin
         unlock_r  <= 1'b1;
         unl_cnt_r <= 3'h0;
      end
   end

   // Divider moves to a new setting only at a period boundary,
   // so no period is ever shorter than either setting allows.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         div_cnt_r <= 9'h000;
         act_sel_r <= `CKD_SEL_RST;
      end else if (div_cnt_r >= div_last(act_sel_r)) begin
         div_cnt_r <= 9'h000;
         act_sel_r <= sel_r;
      end else begin
         div_cnt_r <= div_cnt_r + 9'h001;
      end
   end

   assign tick = div_cnt_r >= div_last(act_sel_r);

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         arm_r     <= 1'b0;
         mode_r    <= 2'h0;
         cmp_dis_r <= 1'b0;
      end else if (wr && PADDR == `CKD_ADDR_PWRCTL) begin
         arm_r  <= PWDATA[`CKD_BIT_ARM];
         mode_r <= PWDATA[`CKD_MODE_HI:`CKD_MODE_LO];
      end else if (wr && PADDR == `CKD_ADDR_CMPCTL) begin
         cmp_dis_r <= PWDATA[`CKD_BIT_CMPDIS];
      end
   end

   always_comb begin
      unique case (slp_mode_r)
         CKD_IDLE: begin
            wake = WAKE_IRQ.external_interrupt_zero_level || WAKE_IRQ.pin_change
                   || WAKE_IRQ.watchdog || WAKE_IRQ.adc_done
                   || WAKE_IRQ.mem_ready || WAKE_IRQ.other_io
                   || (WAKE_IRQ.comparator && !cmp_dis_r);
         end
         CKD_NOISE: begin
            wake = WAKE_IRQ.external_interrupt_zero_level || WAKE_IRQ.pin_change
                   || WAKE_IRQ.watchdog || WAKE_IRQ.adc_done
                   || WAKE_IRQ.mem_ready;
         end
         default: begin
            wake = WAKE_IRQ.external_interrupt_zero_level || WAKE_IRQ.pin_change
                   || WAKE_IRQ.watchdog;
         end
      endcase
   end

   // Resets wake via RST_B, which restarts from the reset vector
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r    <= CKD_RUN;
         slp_mode_r <= CKD_IDLE;
         wait_r     <= 4'h0;
      end else begin
         unique case (state_r)
            CKD_RUN: begin
               if (SLEEP_INSTR && arm_r
                   && mode_r != 2'(CKD_RSVD)) begin
                  state_r    <= CKD_SLEEP;
                  slp_mode_r <= ckd_mode_e'(mode_r);
               end
            end
            CKD_SLEEP: begin
               if (wake) begin
                  state_r <= CKD_START;
                  wait_r  <= 4'h0;
               end
            end
            CKD_START: begin
               // Only power-down restarts the oscillator
               if (slp_mode_r != CKD_PDOWN
                   || wait_r == `CKD_STARTUP_CYC - 4'h1) begin
                  state_r <= CKD_HOLD;
                  wait_r  <= 4'h0;
               end else begin
                  wait_r <= wait_r + 4'h1;
               end
            end
            CKD_HOLD: begin
               if (wait_r == 4'({1'b0, `CKD_HOLD_CYC}) - 4'h1) begin
                  state_r <= CKD_RUN;
               end else begin
                  wait_r <= wait_r + 4'h1;
               end
            end
         endcase
      end
   end

   // Only clocks are gated; storage is never reset by sleep
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         CLK_EN     <= '0;
         OSC_ENABLE <= 1'b1;
      end else begin
         CLK_EN.cpu   <= tick && state_r == CKD_RUN;
         CLK_EN.flash <= tick && state_r == CKD_RUN;
         CLK_EN.io    <= tick && (state_r == CKD_RUN
                         || slp_mode_r == CKD_IDLE);
         CLK_EN.adc   <= tick && (state_r == CKD_RUN
                         || slp_mode_r != CKD_PDOWN);
         OSC_ENABLE   <= !(state_r == CKD_SLEEP
                           && slp_mode_r == CKD_PDOWN);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ADC_AUTO_START <= 1'b0;
         INTR_WAKE      <= 1'b0;
         SLEEPING       <= 1'b0;
      end else begin
         ADC_AUTO_START <= state_r == CKD_RUN && SLEEP_INSTR && arm_r
                           && ADC_ENABLED
                           && mode_r[1] == 1'b0;
         INTR_WAKE      <= state_r == CKD_HOLD
                           && wait_r == 4'({1'b0, `CKD_HOLD_CYC}) - 4'h1;
         SLEEPING       <= state_r != CKD_RUN;
      end
   end

   always_comb begin
      clkdiv_rd = {unlock_r, 3'h0, sel_r};
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PRDATA <= 32'h0000_0000;
      end else if (rd && !PENABLE) begin
         unique case (PADDR)
            `CKD_ADDR_CLKDIV: PRDATA <= {24'h00_0000, clkdiv_rd};
            `CKD_ADDR_PWRCTL: PRDATA <= {26'h000_0000, arm_r, mode_r, 3'h0};
            `CKD_ADDR_CMPCTL: PRDATA <= {24'h00_0000, cmp_dis_r, 7'h00};
            `CKD_ADDR_STATUS: PRDATA <= {28'h000_0000, act_sel_r};
            default:          PRDATA <= 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- ckd_clock_sleep_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module ckd_chk
   import ckd_pkg::*;
(
   input wire logic        SYS_CLK,
   input wire logic        RST_B,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        SLEEP_INSTR,
   input wire logic        ADC_ENABLED,
   input wire ckd_wake_s   WAKE_IRQ,
   input wire ckd_clken_s  CLK_EN,
   input wire logic        OSC_ENABLE,
   input wire logic        ADC_AUTO_START,
   input wire logic        INTR_WAKE,
   input wire logic        SLEEPING
);
   logic [1:0] mode_r;
   // Shadow of the mode field, since the checker cannot see registers
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_r <= 2'h0;
      end else if (PSEL && PENABLE && PWRITE && PADDR == 12'h004) begin
         mode_r <= PWDATA[4:3];
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   rsvd_zero_a: assert property (PSEL && PENABLE && !PWRITE &&
      PADDR == 12'h000 |-> PRDATA[31:8] == 24'h0 && PRDATA[6:4] == 3'h0)
      else $error("bits set");
   // Instruction edge, then state edge, then the registered flag
   sleep_entry_a: assert property ($rose(SLEEPING) |->
      $past(SLEEP_INSTR, 2)) else $error("sleep without instruction");
   idle_gate_a: assert property (SLEEPING |->
      !CLK_EN.cpu && !CLK_EN.flash) else $error("cpu clock runs");
   noise_gate_a: assert property (SLEEPING && mode_r == 2'h1 |->
      !CLK_EN.io) else $error("io clock runs");
   pdown_gate_a: assert property (!OSC_ENABLE |->
      CLK_EN == 4'h0) else $error("clock without oscillator");
   // Request level is still up in the cycle of the release pulse
   idle_wake_a: assert property (SLEEPING && mode_r == 2'h0 &&
      !INTR_WAKE && |(WAKE_IRQ & 7'h7D) |-> ##[1:12] INTR_WAKE)
      else $error("no wake");
   wake_pulse_a: assert property (INTR_WAKE |=>
      !INTR_WAKE && !SLEEPING) else $error("wake pulse wrong");
   // Start pulse leads the sleeping flag by one cycle
   adc_start_a: assert property (ADC_AUTO_START |-> ADC_ENABLED &&
      mode_r != 2'h2 ##1 SLEEPING) else $error("bad adc start");
endmodule
bind ckd_clock_sleep ckd_chk u_chk (.*);
`default_nettype wire

// ---- ckd_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ckd_cpu_model
   import ckd_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_b,
   input  wire logic      sleep_go,
   input  wire logic      intr_wake,
   input  wire ckd_wake_s wake_req,
   output logic           sleep_instr,
   output ckd_wake_s      wake_lvl
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_instr <= 1'b0;
      end else begin
         sleep_instr <= sleep_go;
      end
   end
   // Level held until serviced, else a short pulse may be missed
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_lvl <= '0;
      end else begin
         wake_lvl <= intr_wake ? '0 : (wake_lvl | wake_req);
      end
   end
endmodule
`default_nettype wire

// ---- ckd_clock_sleep_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   num_errors++; $display("wrong value at %0t: got %0h", $time, (a)); end end
module ckd_clock_sleep_test
   import ckd_pkg::*;
;
   logic        SYS_CLK = 1'b0;
   logic        RST_B = 1'b0;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic        PREADY, PSLVERR, INTR_WAKE, SLEEPING, OSC_ENABLE;
   logic        ADC_AUTO_START, SLEEP_INSTR;
   logic        ADC_ENABLED = 1'b0;
   logic        sleep_go = 1'b0;
   ckd_wake_s   wake_req = '0;
   ckd_wake_s   WAKE_IRQ;
   ckd_clken_s  CLK_EN;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          n, sel, m;
   integer      seed = 32'h745F;
   logic [31:0] exp_q[$];
   ckd_cpu_model cpu (.clk(SYS_CLK), .rst_b(RST_B), .sleep_go(sleep_go),
      .intr_wake(INTR_WAKE), .wake_req(wake_req),
      .sleep_instr(SLEEP_INSTR), .wake_lvl(WAKE_IRQ));
   ckd_clock_sleep uut (.*, .DIVIDE_BY_EIGHT_FUSE(1'b1));
   initial forever #50 SYS_CLK = ~SYS_CLK;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      repeat (20) begin
         @(posedge SYS_CLK);
         if (PREADY === 1'b1) break;
      end
      `CHK(PREADY, 1'b1)
      if (PREADY !== 1'b1) give_verdict();
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic kick(input logic s, input ckd_wake_s w);
      sleep_go <= s;
      wake_req <= w;
      @(posedge SYS_CLK);
      sleep_go <= 1'b0;
      wake_req <= '0;
      repeat (20) @(posedge SYS_CLK);
   endtask
   always @(posedge SYS_CLK) begin
      if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
         `CHK(PRDATA, exp_q.pop_front())
      end
   end
   initial begin
      repeat (4) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      rd(12'h000, 32'h3);
      apb(1'b1, 12'h000, 32'h81);
      rd(12'h000, 32'h3);
      apb(1'b1, 12'h000, 32'h80);
      rd(12'h000, 32'h83);
      rd(12'h000, 32'h3);
      apb(1'b1, 12'h000, 32'h80);
      apb(1'b1, 12'h000, 32'h80);
      repeat (2) @(posedge SYS_CLK);
      apb(1'b1, 12'h000, 32'h7);
      rd(12'h000, 32'h3);
      apb(1'b1, 12'h010, 32'hFF);
      rd(12'h010, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         sel = (i == 4) ? 0 : $unsigned($random(seed)) % 9;
         apb(1'b1, 12'h000, 32'h80);
         apb(1'b1, 12'h000, 32'(sel));
         rd(12'h000, 32'(sel));
         repeat (800) @(posedge SYS_CLK);
         n = 0;
         repeat (256) begin
            @(posedge SYS_CLK);
            n += CLK_EN.cpu + CLK_EN.io;
         end
         `CHK(n, 512 >> sel)
      end
      $display("test divider done");
      for (m = 0; m < 3; m++) begin
         ADC_ENABLED <= m[0];
         apb(1'b1, 12'h004, 32'(m << 3));
         kick(1'b1, '0);
         `CHK(SLEEPING, 1'b0)
         apb(1'b1, 12'h004, 32'h20 | 32'(m << 3));
         kick(1'b1, '0);
         `CHK(OSC_ENABLE, 1'(m != 2))
         if (m != 0) kick(1'b0, 7'h01);
         `CHK(SLEEPING, 1'b1)
         wake_req <= 7'h20;
         repeat (40) begin
            @(posedge SYS_CLK);
            wake_req <= '0;
            if (INTR_WAKE === 1'b1) break;
         end
         `CHK(INTR_WAKE, 1'b1)
         if (INTR_WAKE !== 1'b1) give_verdict();
      end
      kick(1'b1, '0);
      RST_B <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      @(posedge SYS_CLK);
      `CHK(SLEEPING, 1'b0)
      @(posedge SYS_CLK);
      rd(12'h000, 32'h3);
      $display("test sleep done");
      give_verdict();
   end
endmodule
`default_nettype wire
